//--- logic/ipe_pkg.sv
/*
  Constants for the insulation state PWM encoder: clock rate, carrier
  frequencies, duty figures in tenths of a percent, timing.
  Assumes a single 50 MHz system clock shared by every file of the block.
*/
// Summary of operation
// R01: Normal carrier 10 Hz, undervoltage 20 Hz; duty carries insulation resistance.
// R02: Duty 5 % at 50 Mohm and above, 50 % at 1200 kohm, 95 % at zero.
// R03: Duty held in 5..95 %, encoded as inverse of receiver resistance formula.
// R04: Alarm raised while resistance is below the response threshold.
// R05: Quick start uses 30 Hz; good verdict sent as 5..10 % duty.
// R06: Quick start bad verdict sent as 90..95 % duty.
// R07: Device error 40 Hz, chassis return fault 50 Hz, duty 47.5..52.5 %.
// R08: Earth wire and functional faults reported on separate status output.
// R09: After power-on, quick start for two seconds, then pulse method.
// R10: Self test never alters or interrupts the PWM or status outputs.
// R11: Mode and duty changes take effect only at a PWM period boundary.
package ipe_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;

  // Carrier frequencies in Hz
  localparam int unsigned FREQ_NORMAL_HZ = 10;
  localparam int unsigned FREQ_UNDERVOLT_HZ = 20;
  localparam int unsigned FREQ_QUICK_HZ = 30;
  localparam int unsigned FREQ_DEV_ERR_HZ = 40;
  localparam int unsigned FREQ_CHASSIS_HZ = 50;

  // Period lengths in clock cycles (a period is rounded down)
  localparam int unsigned PER_NORMAL = CLK_HZ / FREQ_NORMAL_HZ;
  localparam int unsigned PER_UNDERVOLT = CLK_HZ / FREQ_UNDERVOLT_HZ;
  localparam int unsigned PER_QUICK = CLK_HZ / FREQ_QUICK_HZ;
  localparam int unsigned PER_DEV_ERR = CLK_HZ / FREQ_DEV_ERR_HZ;
  localparam int unsigned PER_CHASSIS = CLK_HZ / FREQ_CHASSIS_HZ;

  // Quick start window after reset, in ms and in cycles
  localparam int unsigned QUICK_TIME_MS = 2000;
  localparam int unsigned QUICK_CYCLES = QUICK_TIME_MS * (CLK_HZ / 1000);

  // Duty figures in permille
  localparam logic [9:0] DUTY_MIN = 10'h032;
  localparam logic [9:0] DUTY_MAX = 10'h3B6;
  localparam logic [9:0] DUTY_GOOD = 10'h04B;
  localparam logic [9:0] DUTY_BAD = 10'h39D;
  localparam logic [9:0] DUTY_ERROR = 10'h1F4;
  localparam int unsigned DUTY_SCALE = 1000;

  // Duty formula: span 900 permille, reference resistance 1200 kohm
  localparam logic [9:0] DUTY_SPAN = 10'h384;
  localparam logic [16:0] REF_KOHM = 17'h004B0;

  localparam int CNT_W = 27;

  typedef enum logic [2:0] {
    IPE_NORMAL = 3'b000,
    IPE_UNDERVOLT = 3'b001,
    IPE_QUICK = 3'b010,
    IPE_DEV_ERR = 3'b011,
    IPE_CHASSIS = 3'b100
  } ipe_mode_t;

endpackage

//--- logic/ipe_pwm_core.sv
/*
  Period counter and comparator producing one PWM output.
  Assumes period and high time are held stable by the caller and are
  sampled only when a period completes.
*/
`timescale 1ns/10ps
`default_nettype none

module ipe_pwm_core (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Shape of the next period
  input wire logic [ipe_pkg::CNT_W-1:0] period_i,
  input wire logic [ipe_pkg::CNT_W-1:0] high_i,
  // Output
  output logic pwm_o,
  output logic boundary_o
);

  logic [ipe_pkg::CNT_W-1:0] count;
  logic [ipe_pkg::CNT_W-1:0] cur_period;
  logic [ipe_pkg::CNT_W-1:0] cur_high;
  wire last_cycle = (count >= cur_period - 1'b1);
  wire [ipe_pkg::CNT_W-1:0] next_count = last_cycle ? '0 : count + 1'b1;
  wire next_pwm = last_cycle ? (high_i != '0) : (next_count < cur_high);

  // ==========================================================
  // Counter; the shape is reloaded only at the period end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      count <= '0;
      // One-cycle period, so the first real shape loads at once
      cur_period <= {{(ipe_pkg::CNT_W-1){1'b0}}, 1'b1};
      cur_high <= '0;
      pwm_o <= 1'b0;
      boundary_o <= 1'b0;
    end else begin
      count <= next_count;
      pwm_o <= next_pwm;
      boundary_o <= last_cycle;
      if (last_cycle) begin
        cur_period <= period_i; // R11
        cur_high <= high_i; // R11
      end
    end
  end

endmodule

`default_nettype wire

//--- logic/ipe_encoder.sv
/*
  Insulation state PWM encoder: selects carrier and duty from the operating
  condition and insulation resistance, drives the measured value output,
  the fault status output and an insulation alarm.
  Assumes the measurement front end supplies resistance in kohm and fault
  flags from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

module ipe_encoder #(
  parameter int unsigned QUICK_CYCLES = ipe_pkg::QUICK_CYCLES,
  parameter int unsigned PER_NORMAL = ipe_pkg::PER_NORMAL,
  parameter int unsigned PER_UNDERVOLT = ipe_pkg::PER_UNDERVOLT,
  parameter int unsigned PER_QUICK = ipe_pkg::PER_QUICK,
  parameter int unsigned PER_DEV_ERR = ipe_pkg::PER_DEV_ERR,
  parameter int unsigned PER_CHASSIS = ipe_pkg::PER_CHASSIS
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Measurement front end
  input wire logic [15:0] resistance_kohm_i,
  input wire logic [15:0] response_threshold_i,
  input wire logic undervoltage_i,
  input wire logic device_error_i,
  input wire logic chassis_return_fault_i,
  input wire logic earth_wire_fault_i,
  input wire logic self_test_i,
  // Outputs
  output logic measured_value_output_o,
  output logic fault_status_output_o,
  output logic insulation_alarm_o,
  output logic quick_start_measurement_o
);

  // ==========================================================
  // Start-up sequencing
  logic [ipe_pkg::CNT_W-1:0] quick_count;
  logic quick_phase;
  wire quick_done = (quick_count >= ipe_pkg::CNT_W'(QUICK_CYCLES - 1));

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      quick_count <= '0;
      quick_phase <= 1'b1;
    end else if (quick_phase) begin
      quick_count <= quick_count + 1'b1;
      quick_phase <= !quick_done; // R09
    end
  end

  // ==========================================================
  // Held measurement; frozen while the self test runs so the
  // outputs keep showing the last good reading
  logic [15:0] held_kohm;
  logic held_alarm;
  wire live_alarm = (resistance_kohm_i < response_threshold_i); // R04

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      held_kohm <= '0;
      held_alarm <= 1'b0;
    end else if (!self_test_i) begin
      held_kohm <= resistance_kohm_i; // R10
      held_alarm <= live_alarm; // R10
    end
  end

  // ==========================================================
  // Mode selection; errors override the measurement modes
  ipe_pkg::ipe_mode_t mode;
  assign mode = device_error_i ? ipe_pkg::IPE_DEV_ERR :
                chassis_return_fault_i ? ipe_pkg::IPE_CHASSIS :
                quick_phase ? ipe_pkg::IPE_QUICK :
                undervoltage_i ? ipe_pkg::IPE_UNDERVOLT :
                ipe_pkg::IPE_NORMAL;

  // ==========================================================
  // Resistance to duty: 50 + 900 * 1200 / (R + 1200) permille.
  // The divider is combinational; timing is relaxed since the
  // result is only taken once per period.
  wire [16:0] denom = {1'b0, held_kohm} + ipe_pkg::REF_KOHM;
  wire [20:0] numer = 21'(ipe_pkg::DUTY_SPAN) * 21'(ipe_pkg::REF_KOHM);
  wire [20:0] quot = numer / 21'(denom);
  wire [9:0] res_duty_raw = 10'(quot[9:0] + ipe_pkg::DUTY_MIN); // R03
  // 50 Mohm and above is sent as the 5 % floor, read back as open
  localparam logic [15:0] OPEN_KOHM = 16'hC350;
  wire open_band = (held_kohm >= OPEN_KOHM); // R02
  wire [9:0] res_duty = open_band ? ipe_pkg::DUTY_MIN :
                        (res_duty_raw > ipe_pkg::DUTY_MAX) ? ipe_pkg::DUTY_MAX :
                        (res_duty_raw < ipe_pkg::DUTY_MIN) ? ipe_pkg::DUTY_MIN :
                        res_duty_raw; // R02 R03

  logic [9:0] duty;
  logic [ipe_pkg::CNT_W-1:0] period;

  always_comb begin
    duty = res_duty;
    period = ipe_pkg::CNT_W'(PER_NORMAL);
    unique case (mode)
      ipe_pkg::IPE_NORMAL: begin
        duty = res_duty; // R01
        period = ipe_pkg::CNT_W'(PER_NORMAL); // R01
      end
      ipe_pkg::IPE_UNDERVOLT: begin
        duty = res_duty; // R01
        period = ipe_pkg::CNT_W'(PER_UNDERVOLT); // R01
      end
      ipe_pkg::IPE_QUICK: begin
        duty = held_alarm ? ipe_pkg::DUTY_BAD : ipe_pkg::DUTY_GOOD; // R05 R06
        period = ipe_pkg::CNT_W'(PER_QUICK); // R05
      end
      ipe_pkg::IPE_DEV_ERR: begin
        duty = ipe_pkg::DUTY_ERROR; // R07
        period = ipe_pkg::CNT_W'(PER_DEV_ERR); // R07
      end
      ipe_pkg::IPE_CHASSIS: begin
        duty = ipe_pkg::DUTY_ERROR; // R07
        period = ipe_pkg::CNT_W'(PER_CHASSIS); // R07
      end
      default: begin
        duty = ipe_pkg::DUTY_ERROR;
        period = ipe_pkg::CNT_W'(PER_DEV_ERR);
      end
    endcase
  end

  wire [ipe_pkg::CNT_W+9:0] high_prod = (ipe_pkg::CNT_W+10)'(period) * (ipe_pkg::CNT_W+10)'(duty);
  wire [ipe_pkg::CNT_W-1:0] high = ipe_pkg::CNT_W'(high_prod / (ipe_pkg::CNT_W+10)'(ipe_pkg::DUTY_SCALE));

  // ==========================================================
  // PWM generation
  logic pwm;
  logic boundary;

  ipe_pwm_core u_core (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .period_i(period),
    .high_i(high),
    .pwm_o(pwm),
    .boundary_o(boundary)
  );

  // ==========================================================
  // Outputs; status is high while healthy, and the quick start
  // flag follows the carrier at period ends only
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      measured_value_output_o <= 1'b0;
      fault_status_output_o <= 1'b0;
      insulation_alarm_o <= 1'b0;
      quick_start_measurement_o <= 1'b1;
    end else begin
      measured_value_output_o <= pwm;
      fault_status_output_o <= !(earth_wire_fault_i || device_error_i ||
                                  chassis_return_fault_i || held_alarm); // R08
      insulation_alarm_o <= held_alarm; // R04
      if (boundary) begin
        quick_start_measurement_o <= quick_phase; // R11
      end
    end
  end

endmodule

`default_nettype wire

//--- bench/ipe_asserts.sv
/* Port checker for ipe_encoder.
   Bound from tb; one clock, reset high. */
`timescale 1ns/10ps
`default_nettype none
module ipe_asserts #(
  parameter int unsigned PER_NORMAL = 100,
  parameter int unsigned PER_UNDERVOLT = 50,
  parameter int unsigned PER_QUICK = 30,
  parameter int unsigned PER_DEV_ERR = 40,
  parameter int unsigned PER_CHASSIS = 20
) (
  // Inputs
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [15:0] resistance_kohm_i,
  input wire logic [15:0] response_threshold_i,
  input wire logic device_error_i,
  input wire logic chassis_return_fault_i,
  input wire logic earth_wire_fault_i,
  input wire logic self_test_i,
  // Outputs
  input wire logic measured_value_output_o,
  input wire logic fault_status_output_o,
  input wire logic insulation_alarm_o,
  input wire logic quick_start_measurement_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // ==========
  // Rise to rise count; first rise after reset is not judged
  logic q;
  logic seen;
  logic [31:0] cnt;
  wire logic rise = measured_value_output_o && !q;
  always_ff @(posedge ref_clk_i) begin
    q <= rst_i ? 1'b0 : measured_value_output_o;
    seen <= rst_i ? 1'b0 : (seen | rise);
    cnt <= (rst_i || rise) ? 32'h1 : cnt + 32'h1;
  end
  property p_period;
    rise && seen |-> cnt inside {PER_NORMAL, PER_UNDERVOLT, PER_QUICK, PER_DEV_ERR, PER_CHASSIS};
  endproperty
  a_period: assert property (p_period) else $error("pwm period length");
  property p_err; device_error_i |=> !fault_status_output_o; endproperty
  a_err: assert property (p_err) else $error("status on device error");
  property p_chas; chassis_return_fault_i |=> !fault_status_output_o; endproperty
  a_chas: assert property (p_chas) else $error("status on return fault");
  property p_earth; earth_wire_fault_i |=> !fault_status_output_o; endproperty
  a_earth: assert property (p_earth) else $error("status on earth fault");
  property p_al_set;
    (!$past(rst_i) && !self_test_i && resistance_kohm_i < response_threshold_i) [*2] |=> insulation_alarm_o;
  endproperty
  a_al_set: assert property (p_al_set) else $error("alarm not raised");
  property p_al_clr;
    (!self_test_i && resistance_kohm_i >= response_threshold_i) [*2] |=> !insulation_alarm_o;
  endproperty
  a_al_clr: assert property (p_al_clr) else $error("alarm not cleared");
  property p_st; self_test_i [*3] |=> $stable(insulation_alarm_o); endproperty
  a_st: assert property (p_st) else $error("alarm moved in self test");
  property p_qk; !quick_start_measurement_o |=> !quick_start_measurement_o; endproperty
  a_qk: assert property (p_qk) else $error("quick phase came back");
  c_rise: cover property (rise && seen);
  c_al: cover property ($rose(insulation_alarm_o));
  c_flt: cover property ($fell(fault_status_output_o));
endmodule
`default_nettype wire

//--- bench/ipe_ctrl_model.sv
/* Controller model: times the measured value line rise to rise.
   Shares the encoder clock. */
`timescale 1ns/10ps
`default_nettype none
module ipe_ctrl_model (
  // Clock and line
  input wire logic ref_clk_i,
  input wire logic pwm_i,
  // Decoded shape and rise count
  output logic [31:0] period_o,
  output logic [31:0] high_o,
  output logic [31:0] samples_o
);
  logic prev = 1'b0;
  logic [31:0] cnt = 32'h0;
  logic [31:0] hcnt = 32'h0;
  initial samples_o = 32'h0;
  // Period and high time recovered per carrier cycle
  always @(posedge ref_clk_i) begin
    prev <= pwm_i;
    cnt <= cnt + 32'h1;
    hcnt <= hcnt + {31'h0, pwm_i};
    if (pwm_i && !prev) begin
      period_o <= cnt;
      high_o <= hcnt;
      samples_o <= samples_o + 32'h1;
      cnt <= 32'h1;
      hcnt <= 32'h1;
    end
  end
endmodule
`default_nettype wire

//--- bench/tb.sv
/* Self-checking bench for ipe_encoder.
   Short period parameters; controller model times the output. */
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int unsigned PN = 100;
  localparam int unsigned PU = 50;
  localparam int unsigned PQ = 30;
  localparam int unsigned PD = 40;
  localparam int unsigned PC = 20;
  localparam int unsigned QC = 200;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] res = 16'h1388;
  logic [15:0] thr = 16'h0064;
  logic uv = 1'b0;
  logic derr = 1'b0;
  logic chas = 1'b0;
  logic earth = 1'b0;
  logic st = 1'b0;
  logic pwm, ok, alarm, quick;
  logic [31:0] per_m, high_m, smp_m;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  ipe_encoder #(.QUICK_CYCLES(QC), .PER_NORMAL(PN), .PER_UNDERVOLT(PU), .PER_QUICK(PQ),
    .PER_DEV_ERR(PD), .PER_CHASSIS(PC)) u_ipe_encoder (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .resistance_kohm_i(res), .response_threshold_i(thr), .undervoltage_i(uv),
    .device_error_i(derr), .chassis_return_fault_i(chas), .earth_wire_fault_i(earth),
    .self_test_i(st), .measured_value_output_o(pwm), .fault_status_output_o(ok),
    .insulation_alarm_o(alarm), .quick_start_measurement_o(quick));
  ipe_ctrl_model u_ipe_ctrl_model (.ref_clk_i(ref_clk_i), .pwm_i(pwm), .period_o(per_m),
    .high_o(high_m), .samples_o(smp_m));
  initial forever #10 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      stop_test();
    end
  end
  // ==========
  // Helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // Three rises: skips the period spanning a change and one loaded
  // before the held reading settled
  task automatic meas(input logic [31:0] p, input logic [31:0] h);
    logic [31:0] s;
    int n;
    s = smp_m;
    n = 0;
    while (smp_m < s + 32'h3 && n < 2000) begin
      @(posedge ref_clk_i);
      n++;
    end
    #1;
    chk("period", p, per_m);
    chk("high time", h, high_m);
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========
  // Scenarios; expected high time in clock cycles of the period
  task automatic t_quick(input logic [15:0] r, input logic [31:0] h);
    @(posedge ref_clk_i);
    res <= r;
    rst_i <= 1'b1;
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    tick(1);
    chk("quick flag", 32'h1, quick);
    meas(PQ, h);
  endtask
  task automatic t_after_quick;
    tick(QC);
    chk("quick flag", 32'h0, quick);
    meas(PN, 32'h16);
  endtask
  task automatic t_normal;
    @(posedge ref_clk_i);
    res <= 16'hC350;
    meas(PN, 32'h5);
    @(posedge ref_clk_i);
    res <= 16'h04B0;
    meas(PN, 32'h32);
    @(posedge ref_clk_i);
    res <= 16'h0000;
    meas(PN, 32'h5F);
    chk("alarm", 32'h1, alarm);
    chk("status", 32'h0, ok);
  endtask
  task automatic t_fault;
    @(posedge ref_clk_i);
    res <= 16'h04B0;
    uv <= 1'b1;
    meas(PU, 32'h19);
    @(posedge ref_clk_i);
    uv <= 1'b0;
    derr <= 1'b1;
    meas(PD, 32'h14);
    chk("status", 32'h0, ok);
    @(posedge ref_clk_i);
    derr <= 1'b0;
    chas <= 1'b1;
    meas(PC, 32'hA);
    @(posedge ref_clk_i);
    chas <= 1'b0;
    earth <= 1'b1;
    meas(PN, 32'h32);
    chk("status", 32'h0, ok);
    @(posedge ref_clk_i);
    earth <= 1'b0;
    tick(3);
    chk("status", 32'h1, ok);
  endtask
  task automatic t_self;
    @(posedge ref_clk_i);
    res <= 16'h1388;
    tick(3);
    chk("alarm", 32'h0, alarm);
    @(posedge ref_clk_i);
    st <= 1'b1;
    @(posedge ref_clk_i);
    res <= 16'h0000;
    tick(5);
    chk("alarm", 32'h0, alarm);
    meas(PN, 32'h16);
    @(posedge ref_clk_i);
    st <= 1'b0;
    tick(3);
    chk("alarm", 32'h1, alarm);
  endtask
  initial begin
    t_quick(16'h1388, 32'h2);
    t_after_quick();
    t_normal();
    t_fault();
    t_self();
    t_quick(16'h0032, 32'h1B);
    stop_test();
  end
endmodule
bind ipe_encoder ipe_asserts #(.PER_NORMAL(PER_NORMAL), .PER_UNDERVOLT(PER_UNDERVOLT),
  .PER_QUICK(PER_QUICK), .PER_DEV_ERR(PER_DEV_ERR), .PER_CHASSIS(PER_CHASSIS)) u_ipe_asserts (.*);
`default_nettype wire
